// ===== logic/audio_dac_consts.vh
/*
 * Constants for the stereo DAC serial port: sample width, FIFO depth and clock
 * division ratios.
 * Assumes the block clock is an integer sub-multiple of the 64 MHz top clock.
 */
`ifndef AUDIO_DAC_CONSTS_VH
`define AUDIO_DAC_CONSTS_VH

`define SAMPLE_WIDTH 16
`define FIFO_DEPTH 4
`define FIFO_PTR_WIDTH 2
`define MCLK_HALF_DIV 1
`define BIT_HALF_DIV 2
`define RESET_LEVEL_LOW 1'b0

`endif

// ===== logic/sample_fifo.v
/*
 * Four-word sample FIFO for one audio channel.
 * Assumes writer and reader are on the same clock; writes when full and reads
 * when empty are ignored.
 */
`include "audio_dac_consts.vh"

module sample_fifo #(
  parameter WIDTH = `SAMPLE_WIDTH,
  parameter DEPTH = `FIFO_DEPTH,
  parameter PW = `FIFO_PTR_WIDTH
)(
  // Clock and reset
  input wire clock,
  input wire nrst,
  // Fill side
  input wire wr_en,
  input wire [WIDTH-1:0] wr_data,
  output wire full,
  // Drain side
  input wire rd_en,
  output wire [WIDTH-1:0] rd_data,
  output wire empty,
  output wire [PW:0] level
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [PW-1:0] wr_ptr_ff;
  reg [PW-1:0] rd_ptr_ff;
  reg [PW:0] count_ff;
  wire do_wr;
  wire do_rd;

  assign full = (count_ff == DEPTH);
  assign empty = (count_ff == {(PW+1){1'b0}});
  assign level = count_ff;
  assign rd_data = mem[rd_ptr_ff];
  assign do_wr = wr_en && !full;
  assign do_rd = rd_en && !empty;

  always @(posedge clock)
  begin
    if (do_wr)
      mem[wr_ptr_ff] <= wr_data;
  end

  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_ptr_ff <= {PW{1'b0}};
      rd_ptr_ff <= {PW{1'b0}};
      count_ff <= {(PW+1){1'b0}};
    end
    else
    begin
      if (do_wr)
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      if (do_rd)
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      if (do_wr && !do_rd)
        count_ff <= count_ff + 1'b1;
      else if (do_rd && !do_wr)
        count_ff <= count_ff - 1'b1;
    end
  end
endmodule

// ===== logic/stereo_dac_serial_port.v
/*
 * Stereo DAC serial port: per-channel sample FIFOs, serializer state machine,
 * master clock, channel select clock, refill interrupt and a software I2C port.
 * Assumes the processor side is synchronous to clock and that i2c_data_in
 * arrives from a pin.
 */
// How it works
// - Each channel has its own four-word FIFO for outgoing samples.
// - A state machine loads the shift registers from the FIFOs and sequences the serial pins by itself.
// - A one-cycle refill request pulses whenever the left FIFO's last buffered word moves into the shift registers.
// - The serializer never pauses: an empty FIFO repeats silence rather than stopping the clocks.
// - The DAC control path is a two-bit port whose clock and data levels are set by software, which reads back only the data level.
// - The channel select clock is low while the left sample shifts out and high for the right one.
// - The logic runs from one block clock that is an integer sub-multiple of the 64 MHz top clock.
`include "audio_dac_consts.vh"

module stereo_dac_serial_port #(
  parameter WIDTH = `SAMPLE_WIDTH,
  parameter MCLK_HALF = `MCLK_HALF_DIV,
  parameter BIT_HALF = `BIT_HALF_DIV
)(
  // Clock and reset
  input wire clock,
  input wire nrst,
  // Sample write side
  input wire left_wr,
  input wire [WIDTH-1:0] left_data,
  input wire right_wr,
  input wire [WIDTH-1:0] right_data,
  output reg left_full_ff,
  output reg right_full_ff,
  output reg refill_irq_ff,
  // Software I2C port
  input wire sw_scl,
  input wire sw_sda_drive_low,
  output reg sda_level_ff,
  // DAC serial pins
  output reg master_clock_ff,
  output reg channel_select_clock_ff,
  output reg bit_clock_ff,
  output reg serial_sample_out_ff,
  // DAC control pins
  output reg i2c_clock_ff,
  input wire i2c_data_in,
  output reg i2c_data_out_ff,
  output reg i2c_data_oe_ff
);
  localparam ST_IDLE = 3'b001;
  localparam ST_LEFT = 3'b010;
  localparam ST_RIGHT = 3'b100;
  localparam BW = 5;

  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg [7:0] mdiv_ff;
  reg [7:0] bdiv_ff;
  reg [BW-1:0] bit_cnt_ff;
  reg [WIDTH-1:0] shift_ff;
  reg [WIDTH-1:0] right_hold_ff;
  reg sda_meta_ff;
  wire left_full;
  wire right_full;
  wire left_empty;
  wire right_empty;
  wire [WIDTH-1:0] left_q;
  wire [WIDTH-1:0] right_q;
  wire [`FIFO_PTR_WIDTH:0] left_level;
  wire bit_edge;
  wire word_end;
  wire load_pair;

  // ---------------------------------------------------------------
  // Channel FIFOs
  // ---------------------------------------------------------------
  sample_fifo #(.WIDTH(WIDTH)) u_left_fifo (
    .clock(clock),
    .nrst(nrst),
    .wr_en(left_wr),
    .wr_data(left_data),
    .full(left_full),
    .rd_en(load_pair),
    .rd_data(left_q),
    .empty(left_empty),
    .level(left_level)
  );

  sample_fifo #(.WIDTH(WIDTH)) u_right_fifo (
    .clock(clock),
    .nrst(nrst),
    .wr_en(right_wr),
    .wr_data(right_data),
    .full(right_full),
    .rd_en(load_pair),
    .rd_data(right_q),
    .empty(right_empty),
    .level()
  );

  // ---------------------------------------------------------------
  // Fixed clock dividers
  // ---------------------------------------------------------------
  // The bit edge is a one-cycle enable on the falling edge of the bit clock.
  assign bit_edge = (bdiv_ff == BIT_HALF - 1) && bit_clock_ff;
  assign word_end = bit_edge && (bit_cnt_ff == WIDTH - 1);
  assign load_pair = word_end && (state_ff == ST_RIGHT || state_ff == ST_IDLE);

  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      mdiv_ff <= 8'h00;
      bdiv_ff <= 8'h00;
      master_clock_ff <= 1'b0;
      bit_clock_ff <= 1'b0;
    end
    else
    begin
      if (mdiv_ff == MCLK_HALF - 1)
      begin
        mdiv_ff <= 8'h00;
        master_clock_ff <= !master_clock_ff;
      end
      else
        mdiv_ff <= mdiv_ff + 8'h01;
      if (bdiv_ff == BIT_HALF - 1)
      begin
        bdiv_ff <= 8'h00;
        bit_clock_ff <= !bit_clock_ff;
      end
      else
        bdiv_ff <= bdiv_ff + 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // Serializer state machine
  // ---------------------------------------------------------------
  always @*
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: if (word_end) nxt_state = ST_LEFT;
      ST_LEFT: if (word_end) nxt_state = ST_RIGHT;
      ST_RIGHT: if (word_end) nxt_state = ST_LEFT;
      default: nxt_state = ST_IDLE;
    endcase
  end

  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      state_ff <= ST_IDLE;
      bit_cnt_ff <= {BW{1'b0}};
      shift_ff <= {WIDTH{1'b0}};
      right_hold_ff <= {WIDTH{1'b0}};
      channel_select_clock_ff <= 1'b0;
      serial_sample_out_ff <= 1'b0;
      refill_irq_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      refill_irq_ff <= load_pair && !left_empty && (left_level == 1);
      if (bit_edge)
      begin
        if (word_end)
        begin
          bit_cnt_ff <= {BW{1'b0}};
          if (load_pair)
          begin
            // An empty FIFO sends silence so the stream keeps running.
            shift_ff <= left_empty ? {WIDTH{1'b0}} : left_q;
            right_hold_ff <= right_empty ? {WIDTH{1'b0}} : right_q;
            serial_sample_out_ff <= left_empty ? 1'b0 : left_q[WIDTH-1];
            channel_select_clock_ff <= 1'b0;
          end
          else
          begin
            shift_ff <= right_hold_ff;
            serial_sample_out_ff <= right_hold_ff[WIDTH-1];
            channel_select_clock_ff <= 1'b1;
          end
        end
        else
        begin
          bit_cnt_ff <= bit_cnt_ff + 1'b1;
          shift_ff <= {shift_ff[WIDTH-2:0], 1'b0};
          serial_sample_out_ff <= shift_ff[WIDTH-2];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Software I2C port and status
  // ---------------------------------------------------------------
  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      i2c_clock_ff <= 1'b1;
      i2c_data_out_ff <= 1'b0;
      i2c_data_oe_ff <= 1'b0;
      sda_meta_ff <= 1'b1;
      sda_level_ff <= 1'b1;
      left_full_ff <= 1'b0;
      right_full_ff <= 1'b0;
    end
    else
    begin
      i2c_clock_ff <= sw_scl;
      i2c_data_oe_ff <= sw_sda_drive_low;
      sda_meta_ff <= i2c_data_in;
      sda_level_ff <= sda_meta_ff;
      left_full_ff <= left_full;
      right_full_ff <= right_full;
    end
  end
endmodule

// ===== test/dac_model.sv
/* Behavioural stereo DAC: deserialises the sample stream, holds the data pull-up.
   Assumes serial data is steady at the rising bit clock. */
module dac_model (
  // Serial audio pins
  input wire logic bit_clock,
  input wire logic lr_clock,
  input wire logic sdata,
  // Control pins
  input wire logic sda_oe,
  input wire logic ack_low,
  output wire logic sda_pin,
  // Received words
  output logic word_stb = 1'b0,
  output logic word_right,
  output logic [15:0] word_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] sh = 16'h0000;
  logic lr_prev = 1'b0;
  // Pulled up; either party may pull the line low.
  assign sda_pin = !(sda_oe || ack_low);
  always @(posedge bit_clock)
  begin
    word_stb <= lr_clock != lr_prev;
    word_right <= lr_prev;
    word_data <= sh;
    sh <= {sh[14:0], sdata};
    lr_prev <= lr_clock;
  end
endmodule

// ===== test/dac_port_sva.sv
/* Pin-level assertions for the stereo DAC serial port.
   Bound to the port's top module; sees only its ports. */
module dac_port_sva (
  // Clock and reset
  input wire clock,
  input wire nrst,
  // Pins
  input wire sw_scl,
  input wire sw_sda_drive_low,
  input wire i2c_data_in,
  input wire refill_irq_ff,
  input wire sda_level_ff,
  input wire master_clock_ff,
  input wire channel_select_clock_ff,
  input wire bit_clock_ff,
  input wire serial_sample_out_ff,
  input wire i2c_clock_ff,
  input wire i2c_data_out_ff,
  input wire i2c_data_oe_ff
);
  timeunit 1ns;
  timeprecision 1ns;
  reg [6:0] run_ff;
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // Cycles since the channel clock last moved; parked at 7f until the first move.
  always @(posedge clock or negedge nrst)
    if (!nrst)
      run_ff <= 7'h7f;
    else if ($changed(channel_select_clock_ff))
      run_ff <= 7'h00;
    else if (!run_ff[6])
      run_ff <= run_ff + 7'h01;
  property p_mclk; nrst |=> master_clock_ff != $past(master_clock_ff); endproperty
  a_mclk: assert property (p_mclk) else $error("master clock stuck");
  property p_scl; 1 |=> i2c_clock_ff == $past(sw_scl); endproperty
  a_scl: assert property (p_scl) else $error("i2c clock wrong");
  property p_sdo; 1 |=> i2c_data_oe_ff == $past(sw_sda_drive_low) && !i2c_data_out_ff; endproperty
  a_sdo: assert property (p_sdo) else $error("i2c data drive wrong");
  property p_sdi; 1 |=> ##1 sda_level_ff == $past(i2c_data_in, 2); endproperty
  a_sdi: assert property (p_sdi) else $error("i2c data level wrong");
  property p_bclk; $rose(bit_clock_ff) |-> ##2 $fell(bit_clock_ff) ##2 $rose(bit_clock_ff); endproperty
  a_bclk: assert property (p_bclk) else $error("bit clock period wrong");
  property p_word; $changed(channel_select_clock_ff) && !run_ff[6] |-> run_ff == 7'd63; endproperty
  a_word: assert property (p_word) else $error("word length wrong");
  property p_gap; run_ff != 7'd64; endproperty
  a_gap: assert property (p_gap) else $error("stream stalled");
  property p_edge; $changed(serial_sample_out_ff) |-> $fell(bit_clock_ff); endproperty
  a_edge: assert property (p_edge) else $error("data moved off bit edge");
  property p_irq; refill_irq_ff |-> !channel_select_clock_ff ##1 !refill_irq_ff; endproperty
  a_irq: assert property (p_irq) else $error("refill pulse wrong");
  c_irq: cover property (refill_irq_ff);
  c_right: cover property ($rose(channel_select_clock_ff));
  c_low: cover property (i2c_data_oe_ff && !sda_level_ff);
endmodule

bind stereo_dac_serial_port dac_port_sva i_dac_port_sva (.clock(clock), .nrst(nrst), .sw_scl(sw_scl),
  .sw_sda_drive_low(sw_sda_drive_low), .i2c_data_in(i2c_data_in), .refill_irq_ff(refill_irq_ff),
  .sda_level_ff(sda_level_ff), .master_clock_ff(master_clock_ff), .channel_select_clock_ff(channel_select_clock_ff),
  .bit_clock_ff(bit_clock_ff), .serial_sample_out_ff(serial_sample_out_ff), .i2c_clock_ff(i2c_clock_ff),
  .i2c_data_out_ff(i2c_data_out_ff), .i2c_data_oe_ff(i2c_data_oe_ff));

// ===== test/stereo_dac_serial_port_test.sv
/* Self-checking bench for the stereo DAC serial port.
   A DAC model decodes the stream; the bench drives samples and the I2C port. */
module stereo_dac_serial_port_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, nrst, left_wr, right_wr, sw_scl, sw_sda_drive_low, ack_low;
  logic [15:0] left_data, right_data;
  wire lfull, rfull, irq, sda_lvl, mclk, lrclk, bclk, sdo, scl, sda_out, sda_oe, sda_pin, stb, stb_r;
  wire [15:0] word;
  int err_count = 0, num_checks = 0, cycles = 0, irqs = 0;
  stereo_dac_serial_port i_stereo_dac_serial_port (.clock(clock), .nrst(nrst), .left_wr(left_wr),
    .left_data(left_data), .right_wr(right_wr), .right_data(right_data), .left_full_ff(lfull),
    .right_full_ff(rfull), .refill_irq_ff(irq), .sw_scl(sw_scl), .sw_sda_drive_low(sw_sda_drive_low),
    .sda_level_ff(sda_lvl), .master_clock_ff(mclk), .channel_select_clock_ff(lrclk), .bit_clock_ff(bclk),
    .serial_sample_out_ff(sdo), .i2c_clock_ff(scl), .i2c_data_in(sda_pin), .i2c_data_out_ff(sda_out),
    .i2c_data_oe_ff(sda_oe));
  dac_model i_dac_model (.bit_clock(bclk), .lr_clock(lrclk), .sdata(sdo), .sda_oe(sda_oe), .ack_low(ack_low),
    .sda_pin(sda_pin), .word_stb(stb), .word_right(stb_r), .word_data(word));
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    irqs <= irqs + (irq === 1'b1);
    if (cycles == 3000)
    begin
      err_count++;
      summarize();
    end
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Fills both FIFOs, tries a fifth pair, then follows the stream into silence.
  task automatic test_stream;
    int j;
    for (int i = 0; i < 5; i++)
    begin
      left_wr <= 1'b1;
      right_wr <= 1'b1;
      left_data <= 16'h8101 + 16'(i);
      right_data <= 16'h4c03 + 16'(i);
      @(posedge clock);
    end
    left_wr <= 1'b0;
    right_wr <= 1'b0;
    repeat (3) @(posedge clock);
    #1;
    check({lfull, rfull}, 16'h0003, "full");
    j = 0;
    while (j < 10)
    begin
      @(posedge stb);
      #1;
      if (j > 0 || word !== 16'h0000)
      begin
        check(word, j >= 8 ? 16'h0000 : (j[0] ? 16'h4c03 : 16'h8101) + 16'(j / 2), "word");
        check(stb_r, j[0], "side");
        j++;
      end
    end
    check(16'(irqs), 16'h0001, "irq count");
  endtask
  // Steps the I2C clock every 400 ns and both parties' pulls on the data line.
  task automatic test_i2c;
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clock);
      sw_scl <= i[0];
      sw_sda_drive_low <= i[1];
      ack_low <= i[2];
      repeat (3) @(posedge clock);
      #1;
      check({scl, sda_oe, sda_lvl}, {13'h0, i[0], i[1], !(i[1] | i[2])}, "i2c");
    end
  endtask
  initial
  begin
    nrst = 1'b0;
    {left_wr, right_wr, sw_sda_drive_low, ack_low} = 4'h0;
    sw_scl = 1'b1;
    left_data = 16'h0000;
    right_data = 16'h0000;
    repeat (11) @(posedge clock);
    #1;
    check({lfull, rfull, irq, mclk, lrclk, bclk, sdo, sda_out, sda_oe, scl, sda_lvl}, 16'h0003, "reset");
    @(posedge clock);
    nrst <= 1'b1;
    test_stream();
    test_i2c();
    summarize();
  end
endmodule
